// >>> src/hlie_pkg.sv
// Constants for the low half of the host link interrupt event register
package hlie_pkg;
    localparam int HLIE_EV_W = 21;
    localparam int HLIE_DATA_W = 32;
    localparam int HLIE_ADDR_W = 8;
    localparam logic [HLIE_ADDR_W-1:0] HLIE_SET_OFF = 8'h80;
    localparam logic [HLIE_ADDR_W-1:0] HLIE_CLR_OFF = 8'h84;
    localparam int HLIE_B_CYCLE = 20;
    localparam int HLIE_B_PHY = 19;
    localparam int HLIE_B_BUSRST = 17;
    localparam int HLIE_B_IDDONE = 16;
    localparam int HLIE_B_LOCK = 9;
    localparam int HLIE_B_POSTED = 8;
    localparam int HLIE_B_ISORX = 7;
    localparam int HLIE_B_ISOTX = 6;
    localparam int HLIE_B_RESPONSE_PACKET_STORED = 5;
    localparam int HLIE_B_REQUEST_PACKET_STORED = 4;
    localparam int HLIE_B_ASYNC_RX_RESPONSE_CONTEXT = 3;
    localparam int HLIE_B_ASYNC_RX_REQUEST_CONTEXT = 2;
    localparam int HLIE_B_ASYNC_TX_RESPONSE_CONTEXT = 1;
    localparam int HLIE_B_ASYNC_TX_REQUEST_CONTEXT = 0;
    // Bits that hold a latched flag; the rest are reserved or summaries
    localparam logic [HLIE_EV_W-1:0] HLIE_LATCH_MASK = 21'h1b033f;
    localparam logic [HLIE_EV_W-1:0] HLIE_EV_RESET = 21'h000000;
    localparam logic [HLIE_DATA_W-1:0] HLIE_RD_IDLE = 32'h00000000;
endpackage

// >>> src/hlie_edge_if.sv
// Carrier between the event register and its edge detector
`timescale 1ns/1ps
interface hlie_edge_if #(parameter int W = 21);
    logic [W-1:0] src;
    logic [W-1:0] rise;
    modport owner (output src, input rise);
    modport det (input src, output rise);
endinterface

// >>> src/hlie_edge_det.sv
// Per-bit rising edge detector for the event sources
`timescale 1ns/1ps
module hlie_edge_det
    import hlie_pkg::*;
#(
    parameter int W = HLIE_EV_W
) (
    input wire logic mclk,
    input wire logic nrst,
    hlie_edge_if.det eif
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic prev_reg;
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    prev_reg <= 1'b0;
                end else begin
                    prev_reg <= eif.src[i];
                end
            end
            assign eif.rise[i] = eif.src[i] & ~prev_reg;
        end
    endgenerate
endmodule

// >>> src/hlie_event_low.sv
// Low half of the host link interrupt event register with set, clear and masked read
`timescale 1ns/1ps
module hlie_event_low
    import hlie_pkg::*;
#(
    parameter int RX_CTX = 4,
    parameter int TX_CTX = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [HLIE_ADDR_W-1:0] reg_addr,
    input wire logic [HLIE_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [HLIE_DATA_W-1:0] reg_rdata,
    input wire logic [HLIE_EV_W-1:0] event_mask,
    input wire logic cycle_count_lsb,
    input wire logic phy_status_irq,
    input wire logic phy_bus_reset,
    input wire logic self_id_received,
    input wire logic lock_reply_no_ack,
    input wire logic posted_write_host_err,
    input wire logic [RX_CTX-1:0] iso_rx_event,
    input wire logic [RX_CTX-1:0] iso_rx_mask,
    input wire logic [TX_CTX-1:0] iso_tx_event,
    input wire logic [TX_CTX-1:0] iso_tx_mask,
    input wire logic response_packet_stored,
    input wire logic request_packet_stored,
    input wire logic async_rx_response_context,
    input wire logic async_rx_response_irq,
    input wire logic async_rx_request_context,
    input wire logic async_rx_request_irq,
    input wire logic async_tx_response_context,
    input wire logic async_tx_response_irq,
    input wire logic async_tx_request_context,
    input wire logic async_tx_request_irq,
    output logic [HLIE_EV_W-1:0] event_flags
);
    logic [HLIE_EV_W-1:0] ev_reg;
    logic [HLIE_EV_W-1:0] ev_next;
    logic cyc_prev_reg;
    logic cyc_toggle;
    logic [HLIE_EV_W-1:0] src_vec;
    logic [HLIE_EV_W-1:0] hw_set;
    logic [HLIE_EV_W-1:0] sw_set;
    logic [HLIE_EV_W-1:0] clr_vec;
    logic [HLIE_EV_W-1:0] set_vec;
    logic id_kill;
    logic iso_rx_sum;
    logic iso_tx_sum;
    logic [HLIE_EV_W-1:0] read_val;
    logic addr_hit;

    hlie_edge_if #(.W(HLIE_EV_W)) eif ();

    hlie_edge_det #(.W(HLIE_EV_W)) u_edge (
        .mclk(mclk),
        .nrst(nrst),
        .eif(eif)
    );

    // Level sources; completions count only with their interrupt request
    always_comb begin
        src_vec = '0;
        src_vec[HLIE_B_PHY] = phy_status_irq;
        src_vec[HLIE_B_BUSRST] = phy_bus_reset;
        src_vec[HLIE_B_IDDONE] = self_id_received;
        src_vec[HLIE_B_LOCK] = lock_reply_no_ack;
        src_vec[HLIE_B_POSTED] = posted_write_host_err;
        src_vec[HLIE_B_RESPONSE_PACKET_STORED] = response_packet_stored;
        src_vec[HLIE_B_REQUEST_PACKET_STORED] = request_packet_stored;
        src_vec[HLIE_B_ASYNC_RX_RESPONSE_CONTEXT] = async_rx_response_context & async_rx_response_irq;
        src_vec[HLIE_B_ASYNC_RX_REQUEST_CONTEXT] = async_rx_request_context & async_rx_request_irq;
        src_vec[HLIE_B_ASYNC_TX_RESPONSE_CONTEXT] = async_tx_response_context & async_tx_response_irq;
        src_vec[HLIE_B_ASYNC_TX_REQUEST_CONTEXT] = async_tx_request_context & async_tx_request_irq;
    end
    assign eif.src = src_vec;

    // Both edges of the low cycle bit start a cycle, so this is not an edge detector bit
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cyc_prev_reg <= 1'b0;
        end else begin
            cyc_prev_reg <= cycle_count_lsb;
        end
    end
    assign cyc_toggle = cycle_count_lsb ^ cyc_prev_reg;

    always_comb begin
        hw_set = eif.rise;
        hw_set[HLIE_B_CYCLE] = cyc_toggle;
    end

    assign addr_hit = (reg_addr == HLIE_SET_OFF) || (reg_addr == HLIE_CLR_OFF);
    assign sw_set = (reg_wr && reg_addr == HLIE_SET_OFF) ? reg_wdata[HLIE_EV_W-1:0] : '0;
    assign clr_vec = (reg_wr && reg_addr == HLIE_CLR_OFF) ? reg_wdata[HLIE_EV_W-1:0] : '0;
    // combined set, limited to latched positions
    assign set_vec = (hw_set | sw_set) & HLIE_LATCH_MASK;
    // bus reset turning on drops identification done
    assign id_kill = set_vec[HLIE_B_BUSRST] & ~ev_reg[HLIE_B_BUSRST];

    always_comb begin
        ev_next = ev_reg & ~clr_vec;
        if (id_kill) begin
            ev_next[HLIE_B_IDDONE] = 1'b0;
        end
        // Set beats clear so an event in the clear cycle survives
        ev_next = (ev_next | set_vec) & HLIE_LATCH_MASK;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ev_reg <= HLIE_EV_RESET;
        end else begin
            ev_reg <= ev_next;
        end
    end

    assign iso_rx_sum = |(iso_rx_event & iso_rx_mask);
    assign iso_tx_sum = |(iso_tx_event & iso_tx_mask);

    // masked read view; reserved stay zero via latch mask
    always_comb begin
        read_val = ev_reg;
        read_val[HLIE_B_ISORX] = iso_rx_sum;
        read_val[HLIE_B_ISOTX] = iso_tx_sum;
        read_val = read_val & event_mask;
    end

    // Data stands only in the cycle after the read; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= HLIE_RD_IDLE;
        end else if (reg_rd && addr_hit) begin
            reg_rdata <= {{(HLIE_DATA_W-HLIE_EV_W){1'b0}}, read_val};
        end else begin
            reg_rdata <= HLIE_RD_IDLE;
        end
    end

    assign event_flags = ev_reg;

    a_cycle_toggle_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (cycle_count_lsb != $past(cycle_count_lsb)) |=> ev_reg[HLIE_B_CYCLE])
        else $error("cycle start flag not set after toggle");

    a_phy_edge_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (phy_status_irq && !$past(phy_status_irq)) |=> ev_reg[HLIE_B_PHY])
        else $error("phy request flag not set on edge");

    a_reserved_read_zero: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd |=> (reg_rdata[18] == 1'b0) && (reg_rdata[15:10] == 6'h00) && (reg_rdata[31:21] == 11'h000))
        else $error("reserved bits read nonzero");

    a_bus_reset_kills_id: assert property (@(posedge mclk) disable iff (!nrst)
        (id_kill && !set_vec[HLIE_B_IDDONE]) |=> (ev_reg[HLIE_B_BUSRST] && !ev_reg[HLIE_B_IDDONE]))
        else $error("identification done survived bus reset");

    a_completion_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!ev_reg[HLIE_B_ASYNC_RX_RESPONSE_CONTEXT] && !async_rx_response_irq && sw_set[HLIE_B_ASYNC_RX_RESPONSE_CONTEXT] == 1'b0) |=> !ev_reg[HLIE_B_ASYNC_RX_RESPONSE_CONTEXT])
        else $error("rx response flag set without interrupt request");

    a_rx_summary_read: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit && event_mask[HLIE_B_ISORX])
        |=> (reg_rdata[HLIE_B_ISORX] == $past(|(iso_rx_event & iso_rx_mask))))
        else $error("receive summary read wrong");

    a_tx_summary_read: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit && |(iso_tx_event & iso_tx_mask) && event_mask[HLIE_B_ISOTX]) |=> reg_rdata[HLIE_B_ISOTX])
        else $error("transmit summary read missing");

    a_sw_set_holds: assert property (@(posedge mclk) disable iff (!nrst)
        (|sw_set) |=> ((ev_reg & $past(sw_set) & HLIE_LATCH_MASK) == ($past(sw_set) & HLIE_LATCH_MASK)))
        else $error("software set lost");

    a_clear_takes: assert property (@(posedge mclk) disable iff (!nrst)
        (|clr_vec) |=> ((ev_reg & $past(clr_vec) & ~$past(set_vec)) == '0))
        else $error("software clear ignored");

    a_hold_without_cause: assert property (@(posedge mclk) disable iff (!nrst)
        (set_vec == '0 && clr_vec == '0) |=> (ev_reg == $past(ev_reg)))
        else $error("event flags changed without cause");

    a_read_masked: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit) |=> ((reg_rdata[HLIE_EV_W-1:0] & ~$past(event_mask)) == '0))
        else $error("read shows unmasked bit");

    a_idle_read_zero: assert property (@(posedge mclk) disable iff (!nrst)
        !(reg_rd && addr_hit) |=> (reg_rdata == HLIE_RD_IDLE))
        else $error("read data outside read slot");

    a_held_source_once: assert property (@(posedge mclk) disable iff (!nrst)
        (lock_reply_no_ack && $past(lock_reply_no_ack) && $past(nrst)
        && clr_vec[HLIE_B_LOCK] && !sw_set[HLIE_B_LOCK])
        |=> !ev_reg[HLIE_B_LOCK])
        else $error("held source set flag again");

    // Pin-level checks; a rise on each source line sets its flag one cycle later, with no $past(nrst) term
    a_bus_reset_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (phy_bus_reset && !$past(phy_bus_reset))
        |=> ev_reg[HLIE_B_BUSRST])
        else $error("bus reset flag not set on edge");

    a_id_done_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (self_id_received && !$past(self_id_received))
        |=> ev_reg[HLIE_B_IDDONE])
        else $error("identification done flag not set on edge");

    a_lock_fail_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (lock_reply_no_ack && !$past(lock_reply_no_ack))
        |=> ev_reg[HLIE_B_LOCK])
        else $error("lock reply failure flag not set on edge");

    a_posted_fail_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (posted_write_host_err && !$past(posted_write_host_err))
        |=> ev_reg[HLIE_B_POSTED])
        else $error("deferred write failure flag not set on edge");

    a_resp_stored_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (response_packet_stored && !$past(response_packet_stored))
        |=> ev_reg[HLIE_B_RESPONSE_PACKET_STORED])
        else $error("response stored flag not set on edge");

    a_req_stored_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (request_packet_stored && !$past(request_packet_stored))
        |=> ev_reg[HLIE_B_REQUEST_PACKET_STORED])
        else $error("request stored flag not set on edge");

    a_rx_resp_done_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (async_rx_response_context && async_rx_response_irq
        && !$past(async_rx_response_context && async_rx_response_irq))
        |=> ev_reg[HLIE_B_ASYNC_RX_RESPONSE_CONTEXT])
        else $error("rx response completion flag not set");

    a_rx_req_done_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (async_rx_request_context && async_rx_request_irq
        && !$past(async_rx_request_context && async_rx_request_irq))
        |=> ev_reg[HLIE_B_ASYNC_RX_REQUEST_CONTEXT])
        else $error("rx request completion flag not set");

    a_tx_resp_done_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (async_tx_response_context && async_tx_response_irq
        && !$past(async_tx_response_context && async_tx_response_irq))
        |=> ev_reg[HLIE_B_ASYNC_TX_RESPONSE_CONTEXT])
        else $error("tx response completion flag not set");

    a_tx_req_done_sets: assert property (@(posedge mclk) disable iff (!nrst)
        (async_tx_request_context && async_tx_request_irq
        && !$past(async_tx_request_context && async_tx_request_irq))
        |=> ev_reg[HLIE_B_ASYNC_TX_REQUEST_CONTEXT])
        else $error("tx request completion flag not set");

    // Completions without their interrupt request leave the flag alone
    a_rx_req_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!ev_reg[HLIE_B_ASYNC_RX_REQUEST_CONTEXT] && !async_rx_request_irq && !sw_set[HLIE_B_ASYNC_RX_REQUEST_CONTEXT])
        |=> !ev_reg[HLIE_B_ASYNC_RX_REQUEST_CONTEXT])
        else $error("rx request flag set without interrupt request");

    a_tx_resp_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!ev_reg[HLIE_B_ASYNC_TX_RESPONSE_CONTEXT] && !async_tx_response_irq && !sw_set[HLIE_B_ASYNC_TX_RESPONSE_CONTEXT])
        |=> !ev_reg[HLIE_B_ASYNC_TX_RESPONSE_CONTEXT])
        else $error("tx response flag set without interrupt request");

    a_tx_req_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!ev_reg[HLIE_B_ASYNC_TX_REQUEST_CONTEXT] && !async_tx_request_irq && !sw_set[HLIE_B_ASYNC_TX_REQUEST_CONTEXT])
        |=> !ev_reg[HLIE_B_ASYNC_TX_REQUEST_CONTEXT])
        else $error("tx request flag set without interrupt request");

    a_cycle_steady_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (cycle_count_lsb == $past(cycle_count_lsb) && $past(nrst)
        && !ev_reg[HLIE_B_CYCLE] && !sw_set[HLIE_B_CYCLE])
        |=> !ev_reg[HLIE_B_CYCLE])
        else $error("cycle start flag set without toggle");

    a_phy_held_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (phy_status_irq && $past(phy_status_irq) && $past(nrst)
        && !ev_reg[HLIE_B_PHY] && !sw_set[HLIE_B_PHY])
        |=> !ev_reg[HLIE_B_PHY])
        else $error("held phy request set flag again");

    a_req_held_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (request_packet_stored && $past(request_packet_stored) && $past(nrst)
        && !ev_reg[HLIE_B_REQUEST_PACKET_STORED] && !sw_set[HLIE_B_REQUEST_PACKET_STORED])
        |=> !ev_reg[HLIE_B_REQUEST_PACKET_STORED])
        else $error("held request stored line set flag again");

    a_phy_low_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (!phy_status_irq && !ev_reg[HLIE_B_PHY] && !sw_set[HLIE_B_PHY])
        |=> !ev_reg[HLIE_B_PHY])
        else $error("phy request flag set while line low");

    a_posted_low_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (!posted_write_host_err && !ev_reg[HLIE_B_POSTED] && !sw_set[HLIE_B_POSTED])
        |=> !ev_reg[HLIE_B_POSTED])
        else $error("deferred write flag set while line low");

    a_reset_pin_kills_id: assert property (@(posedge mclk) disable iff (!nrst)
        (phy_bus_reset && !$past(phy_bus_reset) && $past(nrst) && !ev_reg[HLIE_B_BUSRST]
        && !sw_set[HLIE_B_IDDONE] && !(self_id_received && !$past(self_id_received)))
        |=> (ev_reg[HLIE_B_BUSRST] && !ev_reg[HLIE_B_IDDONE]))
        else $error("identification done kept over bus reset entry");

    a_no_stray_latch: assert property (@(posedge mclk) disable iff (!nrst)
        ((ev_reg & ~HLIE_LATCH_MASK) == '0))
        else $error("reserved or summary position latched");

    a_rx_summary_off: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit && !(|(iso_rx_event & iso_rx_mask))) |=> !reg_rdata[HLIE_B_ISORX])
        else $error("receive summary read set with no context event");

    a_tx_summary_off: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit && !(|(iso_tx_event & iso_tx_mask))) |=> !reg_rdata[HLIE_B_ISOTX])
        else $error("transmit summary read set with no context event");

    // Reads: the mask decides each bit, the latched flag supplies it
    a_read_lock_masked: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit)
        |=> (reg_rdata[HLIE_B_LOCK] == ($past(ev_reg[HLIE_B_LOCK]) && $past(event_mask[HLIE_B_LOCK]))))
        else $error("lock failure bit read wrong");

    a_read_cycle_masked: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_rd && addr_hit)
        |=> (reg_rdata[HLIE_B_CYCLE] == ($past(ev_reg[HLIE_B_CYCLE]) && $past(event_mask[HLIE_B_CYCLE]))))
        else $error("cycle start bit read wrong");

    a_flags_sticky: assert property (@(posedge mclk) disable iff (!nrst)
        (!id_kill && (ev_reg & ~clr_vec) != '0)
        |=> ((ev_reg & $past(ev_reg & ~clr_vec)) == $past(ev_reg & ~clr_vec)))
        else $error("flag dropped without clear");

    a_unmapped_write_ignored: assert property (@(posedge mclk) disable iff (!nrst)
        (reg_wr && !addr_hit && set_vec == '0) |=> (ev_reg == $past(ev_reg)))
        else $error("unmapped write changed flags");
endmodule

// >>> tb/hlie_far_model.sv
// Far-side model: turns bench levels into the block's source lines
`timescale 1ns/1ps
module hlie_far_model
    import hlie_pkg::*;
(
    input wire logic [HLIE_EV_W-1:0] lvl,
    input wire logic irq_on,
    output logic cycle_count_lsb,
    output logic phy_status_irq,
    output logic phy_bus_reset,
    output logic self_id_received,
    output logic lock_reply_no_ack,
    output logic posted_write_host_err,
    output logic response_packet_stored,
    output logic request_packet_stored,
    output logic [3:0] ctx,
    output logic [3:0] irq
);
    assign cycle_count_lsb = lvl[20];
    assign phy_status_irq = lvl[19];
    assign phy_bus_reset = lvl[17];
    assign self_id_received = lvl[16];
    assign lock_reply_no_ack = lvl[9];
    assign posted_write_host_err = lvl[8];
    assign response_packet_stored = lvl[5];
    assign request_packet_stored = lvl[4];
    assign ctx = lvl[3:0];
    assign irq = {4{irq_on}};
endmodule

// >>> tb/hlie_event_low_tb.sv
// Self-checking bench for the low event register
`timescale 1ns/1ps
module hlie_event_low_tb
    import hlie_pkg::*;
;
    logic mclk, nrst, reg_wr, reg_rd, irq_on;
    logic [7:0] reg_addr, a;
    logic [31:0] reg_wdata, reg_rdata, seed, d;
    logic [20:0] event_mask, event_flags, lvl, expf;
    logic [3:0] iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask, ctx, irq;
    logic cycle_count_lsb, phy_status_irq, phy_bus_reset, self_id_received;
    logic lock_reply_no_ack, posted_write_host_err, response_packet_stored, request_packet_stored;
    int fails, n_compared;

    hlie_event_low DUT (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_mask,
        .cycle_count_lsb, .phy_status_irq, .phy_bus_reset, .self_id_received, .lock_reply_no_ack,
        .posted_write_host_err, .iso_rx_event, .iso_rx_mask, .iso_tx_event, .iso_tx_mask,
        .response_packet_stored, .request_packet_stored,
        .async_rx_response_context(ctx[3]), .async_rx_response_irq(irq[3]),
        .async_rx_request_context(ctx[2]), .async_rx_request_irq(irq[2]),
        .async_tx_response_context(ctx[1]), .async_tx_response_irq(irq[1]),
        .async_tx_request_context(ctx[0]), .async_tx_request_irq(irq[0]), .event_flags);

    hlie_far_model far (.lvl, .irq_on, .cycle_count_lsb, .phy_status_irq, .phy_bus_reset,
        .self_id_received, .lock_reply_no_ack, .posted_write_host_err, .response_packet_stored,
        .request_packet_stored, .ctx, .irq);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Summaries are unlatched, so they come from the live inputs
    function automatic logic [31:0] rd_exp(input logic [20:0] f);
        logic [20:0] s;
        s = f;
        s[7] = |(iso_rx_event & iso_rx_mask);
        s[6] = |(iso_tx_event & iso_tx_mask);
        return {11'h0, s & event_mask};
    endfunction

    // A set that turns bus reset on drops identification done unless that bit is set too
    function automatic logic [20:0] set_exp(input logic [20:0] f, input logic [20:0] s);
        logic [20:0] n;
        n = f;
        if (s[HLIE_B_BUSRST] && !f[HLIE_B_BUSRST]) begin
            n[HLIE_B_IDDONE] = 1'b0;
        end
        return n | (s & HLIE_LATCH_MASK);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] wa, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= wa;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] ra, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        fails++;
        complete_run();
    end

    initial begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, lvl, expf} = '0;
        {iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask} = '0;
        irq_on = 1'b1;
        event_mask = '1;
        seed = 32'h1908aef5;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1 chk(event_flags, 0);
        for (int b = 0; b < 21; b++) begin
            if (HLIE_LATCH_MASK[b]) begin
                @(posedge mclk);
                lvl[b] <= 1'b1;
                repeat (4) @(posedge mclk);
                #1 chk(event_flags, 32'h1 << b);
                wr(HLIE_CLR_OFF, 32'h1 << b);
                repeat (3) @(posedge mclk);
                #1 chk(event_flags, 0);
                @(posedge mclk);
                lvl[b] <= 1'b0;
                repeat (3) @(posedge mclk);
                #1 chk(event_flags[b], b == 20);
                wr(HLIE_CLR_OFF, 32'h1fffff);
            end
        end
        // Completions without an interrupt request stay silent
        @(posedge mclk);
        irq_on <= 1'b0;
        lvl[3:0] <= 4'hf;
        repeat (4) @(posedge mclk);
        #1 chk(event_flags, 0);
        @(posedge mclk);
        lvl[3:0] <= 4'h0;
        irq_on <= 1'b1;
        wr(HLIE_SET_OFF, 32'h10000);
        @(posedge mclk);
        lvl[17] <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk(event_flags, 32'h20000);
        @(posedge mclk);
        lvl[17] <= 1'b0;
        wr(HLIE_CLR_OFF, 32'hffffffff);
        // A rise landing on the clear edge must win
        fork
            wr(HLIE_CLR_OFF, 32'h80000);
            begin
                @(posedge mclk);
                lvl[19] <= 1'b1;
            end
        join
        #1 chk(event_flags, 32'h80000);
        @(posedge mclk);
        lvl[19] <= 1'b0;
        wr(HLIE_CLR_OFF, 32'h80000);
        #1 chk(event_flags, 0);
        for (int i = 0; i < 40; i++) begin
            d = rnd();
            wr(HLIE_SET_OFF, d);
            expf = set_exp(expf, d[20:0]);
            #1 chk(event_flags, expf);
            d = rnd();
            a = (i % 4 == 3) ? 8'h88 : HLIE_CLR_OFF;
            wr(a, d);
            if (a == HLIE_CLR_OFF) expf = expf & ~d[20:0];
            #1 chk(event_flags, expf);
            d = rnd();
            @(posedge mclk);
            event_mask <= d[20:0];
            {iso_rx_event, iso_rx_mask, iso_tx_event} <= d[31:20];
            iso_tx_mask <= d[3:0];
            rd(i[0] ? HLIE_SET_OFF : HLIE_CLR_OFF, d);
            chk(d, rd_exp(expf));
        end
        // Mid-run reset: flags drop, and a source already high at release sets once
        @(posedge mclk);
        nrst <= 1'b0;
        lvl[9] <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(event_flags, 0);
        @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1 chk(event_flags, 32'h200);
        wr(HLIE_CLR_OFF, 32'h200);
        #1 chk(event_flags, 0);
        @(posedge mclk);
        lvl[9] <= 1'b0;
        rd(8'h40, d);
        chk(d, 0);
        @(posedge mclk);
        #1 chk(reg_rdata, 0);
        complete_run();
    end
endmodule
